// File: design/crs_defines.vh
// Purpose: Constants for the core register set and memory decode
// Assumes: 12-bit address space, 8-bit data
// Notes:   Register port offsets are local choices
`ifndef CRS_DEFINES_VH
`define CRS_DEFINES_VH
// Software port offsets
`define CRS_OFF_ACC       4'h0
`define CRS_OFF_IDX       4'h1
`define CRS_OFF_FLAGS     4'h2
`define CRS_OFF_SPTR      4'h3
`define CRS_OFF_OPCMD     4'h4
`define CRS_OFF_STATUS    4'h5
// Flag bit positions
`define CRS_FLG_C         0
`define CRS_FLG_Z         1
`define CRS_FLG_N         2
`define CRS_FLG_I         3
`define CRS_FLG_H         4
// Reset values
`define CRS_RST_ACC       8'h00
`define CRS_RST_IDX       8'h00
`define CRS_RST_FLAGS     5'h08
`define CRS_RST_SPTR      6'h3f
`define CRS_SP_UPPER      6'h03
// Memory decode
`define CRS_RAM_LO        12'h050
`define CRS_RAM_HI        12'h0ff
`define CRS_PROG_LO       12'h100
`define CRS_PROG_HI       12'hefe
`define CRS_PROG_TOP      12'heff
`define CRS_BOOT_LO       12'hf00
`define CRS_BOOT_HI       12'hfef
`define CRS_VEC_LO        12'hff0
`define CRS_VEC_HI        12'hfff
`define CRS_ERASED_PROG   8'hff
`define CRS_ERASED_OPT    8'h00
// Frame sizes
`define CRS_CALL_BYTES    3'h2
`define CRS_INT_BYTES     3'h5
// Operation codes
`define CRS_OP_NOP        4'h0
`define CRS_OP_ADD        4'h1
`define CRS_OP_ADC        4'h2
`define CRS_OP_SUB        4'h3
`define CRS_OP_AND        4'h4
`define CRS_OP_LDA        4'h5
`define CRS_OP_LDX        4'h6
`define CRS_OP_ASL        4'h7
`define CRS_OP_ROR        4'h8
`define CRS_OP_BTST       4'h9
`define CRS_OP_RSP        4'ha
`define CRS_OP_PUSH       4'hb
`define CRS_OP_PULL       4'hc
`define CRS_OP_CALL       4'hd
`define CRS_OP_INT        4'he
`define CRS_OP_SEI        4'hf
`endif

// File: design/crs_core_regs.v
// Purpose: Programmer-visible core registers, stack pointer and memory decode
// Assumes: Single clock, synchronous active-low reset, clock enable freezes all
// Notes:   Operations are issued through a command register or a command port
//
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "crs_defines.vh"

module crs_core_regs (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        clk_en,
  input  wire [3:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  input  wire        op_valid,
  input  wire [3:0]  op_code,
  input  wire [7:0]  op_data,
  input  wire [2:0]  op_bit,
  input  wire        irq_pulse,
  input  wire [11:0] mem_addr,
  input  wire        mem_erased,
  output wire        sel_ram,
  output wire        sel_prog,
  output wire        sel_boot,
  output wire        sel_vec,
  output wire        sel_io,
  output wire [7:0]  erased_value,
  output wire [11:0] stack_addr,
  output wire        stack_wr,
  output wire        irq_take,
  output wire [7:0]  acc_out,
  output wire [7:0]  idx_out,
  output wire [4:0]  flags_out
);

  // ****************************************
  // State
  // ****************************************
  reg  [7:0] acc_q;
  reg  [7:0] acc_d;
  reg  [7:0] idx_q;
  reg  [7:0] idx_d;
  reg  [4:0] flg_q;
  reg  [4:0] flg_d;
  reg  [5:0] sp_q;
  reg  [5:0] sp_d;
  reg        irq_pend_q;
  reg  [2:0] push_left_q;
  reg  [2:0] push_left_d;
  reg  [7:0] rdata_d;
  reg  [11:0] saddr_q;
  reg  [11:0] saddr_d;
  reg        swr_q;
  reg        swr_d;

  // ****************************************
  // Operation source
  // ****************************************
  // Register-port command wins over the op port in the same cycle
  wire       sw_op   = reg_wr && (reg_addr == `CRS_OFF_OPCMD);
  wire       any_op  = sw_op || op_valid;
  wire [3:0] cur_op  = sw_op ? reg_wdata[3:0] : op_code;
  wire [7:0] operand = sw_op ? idx_q : op_data;
  wire       busy    = (push_left_q != 3'h0);

  // ****************************************
  // Arithmetic unit
  // ****************************************
  wire [8:0] sum9   = {1'b0, acc_q} + {1'b0, operand} +
                      {8'h00, (cur_op == `CRS_OP_ADC) & flg_q[`CRS_FLG_C]};
  wire [4:0] low5   = {1'b0, acc_q[3:0]} + {1'b0, operand[3:0]} +
                      {4'h0, (cur_op == `CRS_OP_ADC) & flg_q[`CRS_FLG_C]};
  wire [8:0] diff9  = {1'b0, acc_q} - {1'b0, operand};
  wire [7:0] tst_v  = operand >> op_bit;

  always @* begin
    acc_d       = acc_q;
    idx_d       = idx_q;
    flg_d       = flg_q;
    sp_d        = sp_q;
    push_left_d = push_left_q;
    saddr_d     = saddr_q;
    swr_d       = 1'b0;
    if (reg_wr && reg_addr == `CRS_OFF_ACC) begin
      acc_d = reg_wdata;
    end
    if (reg_wr && reg_addr == `CRS_OFF_IDX) begin
      idx_d = reg_wdata;
    end
    if (reg_wr && reg_addr == `CRS_OFF_FLAGS) begin
      flg_d = reg_wdata[4:0];
    end
    if (reg_wr && reg_addr == `CRS_OFF_SPTR) begin
      sp_d = reg_wdata[5:0];
    end
    if (busy) begin
      // Multi-byte frame in progress; new ops are ignored until it ends
      saddr_d     = {`CRS_SP_UPPER, sp_q};
      swr_d       = 1'b1;
      sp_d        = sp_q - 6'h01;
      push_left_d = push_left_q - 3'h1;
    end else if (any_op) begin
      case (cur_op)
        `CRS_OP_ADD, `CRS_OP_ADC: begin
          acc_d           = sum9[7:0];
          flg_d[`CRS_FLG_H] = low5[4];
          flg_d[`CRS_FLG_C] = sum9[8];
          flg_d[`CRS_FLG_N] = sum9[7];
          flg_d[`CRS_FLG_Z] = (sum9[7:0] == 8'h00);
        end
        `CRS_OP_SUB: begin
          acc_d           = diff9[7:0];
          flg_d[`CRS_FLG_C] = diff9[8];
          flg_d[`CRS_FLG_N] = diff9[7];
          flg_d[`CRS_FLG_Z] = (diff9[7:0] == 8'h00);
        end
        `CRS_OP_AND: begin
          acc_d           = acc_q & operand;
          flg_d[`CRS_FLG_N] = acc_d[7];
          flg_d[`CRS_FLG_Z] = (acc_d == 8'h00);
        end
        `CRS_OP_LDA: begin
          acc_d           = operand;
          flg_d[`CRS_FLG_N] = operand[7];
          flg_d[`CRS_FLG_Z] = (operand == 8'h00);
        end
        `CRS_OP_LDX: begin
          idx_d           = operand;
          flg_d[`CRS_FLG_N] = operand[7];
          flg_d[`CRS_FLG_Z] = (operand == 8'h00);
        end
        `CRS_OP_ASL: begin
          acc_d           = {acc_q[6:0], 1'b0};
          flg_d[`CRS_FLG_C] = acc_q[7];
          flg_d[`CRS_FLG_N] = acc_q[6];
          flg_d[`CRS_FLG_Z] = (acc_q[6:0] == 7'h00);
        end
        `CRS_OP_ROR: begin
          acc_d           = {flg_q[`CRS_FLG_C], acc_q[7:1]};
          flg_d[`CRS_FLG_C] = acc_q[0];
          flg_d[`CRS_FLG_N] = flg_q[`CRS_FLG_C];
          flg_d[`CRS_FLG_Z] = ({flg_q[`CRS_FLG_C], acc_q[7:1]} == 8'h00);
        end
        `CRS_OP_BTST: begin
          flg_d[`CRS_FLG_C] = tst_v[0];
        end
        `CRS_OP_RSP: begin
          sp_d = `CRS_RST_SPTR;
        end
        `CRS_OP_PUSH: begin
          saddr_d = {`CRS_SP_UPPER, sp_q};
          swr_d   = 1'b1;
          sp_d    = sp_q - 6'h01;
        end
        `CRS_OP_PULL: begin
          sp_d    = sp_q + 6'h01;
          saddr_d = {`CRS_SP_UPPER, sp_d};
        end
        `CRS_OP_CALL: begin
          push_left_d = `CRS_CALL_BYTES;
        end
        `CRS_OP_INT: begin
          push_left_d       = `CRS_INT_BYTES;
          flg_d[`CRS_FLG_I] = 1'b1;
        end
        `CRS_OP_SEI: begin
          flg_d[`CRS_FLG_I] = operand[0];
        end
        default: begin
          acc_d = acc_q;
        end
      endcase
    end
  end

  // ****************************************
  // Interrupt latch
  // ****************************************
  // Taking the request clears the latch, but a new pulse the same cycle wins
  assign irq_take = irq_pend_q && !flg_q[`CRS_FLG_I] && !busy;

  // ****************************************
  // Read path
  // ****************************************
  always @* begin
    rdata_d = 8'h00;
    case (reg_addr)
      `CRS_OFF_ACC:    rdata_d = acc_q;
      `CRS_OFF_IDX:    rdata_d = idx_q;
      `CRS_OFF_FLAGS:  rdata_d = {3'h0, flg_q};
      `CRS_OFF_SPTR:   rdata_d = {2'h0, sp_q};
      `CRS_OFF_STATUS: rdata_d = {4'h0, busy, push_left_q == 3'h0, irq_take, irq_pend_q};
      default:         rdata_d = 8'h00;
    endcase
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      acc_q       <= `CRS_RST_ACC;
      idx_q       <= `CRS_RST_IDX;
      flg_q       <= `CRS_RST_FLAGS;
      sp_q        <= `CRS_RST_SPTR;
      irq_pend_q  <= 1'b0;
      push_left_q <= 3'h0;
      saddr_q     <= {`CRS_SP_UPPER, `CRS_RST_SPTR};
      swr_q       <= 1'b0;
      reg_rdata   <= 8'h00;
    end else if (clk_en) begin
      acc_q       <= acc_d;
      idx_q       <= idx_d;
      flg_q       <= flg_d;
      sp_q        <= sp_d;
      push_left_q <= push_left_d;
      saddr_q     <= saddr_d;
      swr_q       <= swr_d;
      irq_pend_q  <= irq_pulse | (irq_pend_q & !irq_take);
      reg_rdata   <= reg_rd ? rdata_d : 8'h00;
    end
  end

  // ****************************************
  // Memory decode
  // ****************************************
  // Core registers are deliberately absent from this decode
  assign sel_io   = (mem_addr < `CRS_RAM_LO);
  assign sel_ram  = (mem_addr >= `CRS_RAM_LO) && (mem_addr <= `CRS_RAM_HI);
  assign sel_prog = (mem_addr >= `CRS_PROG_LO) && (mem_addr <= `CRS_PROG_TOP);
  assign sel_boot = (mem_addr >= `CRS_BOOT_LO) && (mem_addr <= `CRS_BOOT_HI);
  assign sel_vec  = (mem_addr >= `CRS_VEC_LO);
  // Option byte is the first boot byte; erases to 00 unlike the array
  assign erased_value = !mem_erased ? 8'h00 :
                        (mem_addr == `CRS_BOOT_LO) ? `CRS_ERASED_OPT :
                        `CRS_ERASED_PROG;

  assign stack_addr = saddr_q;
  assign stack_wr   = swr_q;
  assign acc_out    = acc_q;
  assign idx_out    = idx_q;
  assign flags_out  = flg_q;

endmodule
`default_nettype wire

// File: test/crs_asserts.sv
// Purpose: Port-level checks of the core register set
// Assumes: clk_en held high by the bench
// Notes:   Bound into crs_core_regs
`timescale 1ns/1ps
`default_nettype none
`include "crs_defines.vh"
module crs_asserts (
  input wire        clk,
  input wire        rst_n,
  input wire        reg_wr,
  input wire        op_valid,
  input wire [3:0]  op_code,
  input wire [7:0]  op_data,
  input wire        irq_take,
  input wire [11:0] mem_addr,
  input wire        sel_ram,
  input wire [11:0] stack_addr,
  input wire        stack_wr,
  input wire [7:0]  acc_out,
  input wire [4:0]  flags_out
);
  // ********************
  // Properties
  // ********************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Frames refuse ops and the command write overrides the port
  wire op_free = op_valid && !reg_wr && !stack_wr;
  a_stack_window: assert property (stack_addr[11:6] == 6'h03) else $error("stack address off window");
  a_ram_decode: assert property (sel_ram == (mem_addr >= 12'h050 && mem_addr <= 12'h0ff))
    else $error("ram select wrong");
  a_push_step: assert property (stack_wr ##1 stack_wr |-> stack_addr[5:0] == $past(stack_addr[5:0]) - 6'h01)
    else $error("push address step wrong");
  // Frame bytes start one cycle after the op is taken: load, then push
  a_call_frame: assert property (op_free && op_code == `CRS_OP_CALL |=> ##1 stack_wr [*2] ##1 !stack_wr)
    else $error("call frame length wrong");
  a_int_frame: assert property (op_free && op_code == `CRS_OP_INT |=> ##1 stack_wr [*5] ##1 !stack_wr)
    else $error("interrupt frame length wrong");
  a_int_masks: assert property (op_free && op_code == `CRS_OP_INT |=> flags_out[3]) else $error("entry left mask clear");
  a_add_sum: assert property (op_free && op_code == `CRS_OP_ADD |=> {flags_out[0], acc_out} == $past(acc_out) + $past(op_data))
    else $error("add result or carry wrong");
  a_add_half: assert property (op_free && op_code == `CRS_OP_ADD |=> flags_out[4] == ($past(acc_out[3:0]) + $past(op_data[3:0]) > 5'h0f))
    else $error("half carry wrong");
  a_zero_neg: assert property (op_free && (op_code == `CRS_OP_SUB || op_code == `CRS_OP_AND || op_code == `CRS_OP_LDA)
    |=> flags_out[1] == (acc_out == 8'h00) && flags_out[2] == acc_out[7]) else $error("zero or negative flag wrong");
  a_mask_take: assert property (flags_out[3] |-> !irq_take) else $error("interrupt taken while masked");
  a_reset_state: assert property (disable iff (1'b0) !rst_n |=> flags_out == 5'h08 && stack_addr == 12'h0ff)
    else $error("reset state wrong");
  c_int: cover property (op_free && op_code == `CRS_OP_INT);
  c_take: cover property (irq_take);
  c_bottom: cover property (stack_wr && stack_addr == 12'h0c0);
endmodule
bind crs_core_regs crs_asserts i_crs_asserts (.clk, .rst_n, .reg_wr, .op_valid, .op_code, .op_data, .irq_take,
  .mem_addr, .sel_ram, .stack_addr, .stack_wr, .acc_out, .flags_out);
`default_nettype wire

// File: test/tb_top.sv
// Purpose: Self-checking bench for the core register set
// Assumes: 200 MHz clock, clk_en held high, bit index tied to 2
// Notes:   One task per scenario
`timescale 1ns/1ps
`default_nettype none
`include "crs_defines.vh"
module tb_top;
  // ********************
  // Stimulus and checks
  // ********************
  logic        clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, op_valid = 1'b0;
  logic        irq_pulse = 1'b0, mem_erased = 1'b1;
  logic [3:0]  reg_addr = 4'h0, op_code = 4'h0;
  logic [7:0]  reg_wdata = 8'h00, op_data = 8'h00, reg_rdata, acc_out, idx_out, erased_value;
  logic [11:0] mem_addr = 12'h000, stack_addr;
  logic [4:0]  flags_out;
  logic        sel_ram, sel_prog, sel_boot, sel_vec, sel_io, stack_wr, irq_take;
  int          num_errors = 0, num_checks = 0, n;
  always #2.5 clk = ~clk;
  crs_core_regs i_crs_core_regs (.clk, .rst_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .op_valid, .op_code, .op_data, .op_bit(3'h2), .irq_pulse, .mem_addr, .mem_erased, .sel_ram, .sel_prog,
    .sel_boot, .sel_vec, .sel_io, .erased_value, .stack_addr, .stack_wr, .irq_take, .acc_out, .idx_out, .flags_out);
  task automatic chk(input logic [15:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk) reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk) reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  task automatic op(input logic [3:0] c, input logic [7:0] d);
    @(posedge clk) {op_valid, op_code, op_data} <= {1'b1, c, d};
    @(posedge clk) op_valid <= 1'b0;
    #1;
  endtask
  task automatic alu(input logic [3:0] c, input logic [7:0] d, a, input logic [4:0] f, m);
    op(c, d);
    chk(acc_out, a);
    chk(flags_out & m, f);
  endtask
  task automatic frame(input logic [3:0] c, input int len);
    op(c, 8'h00);
    n = 0;
    // Frame counter loads on the op edge; first byte shows one cycle later
    @(posedge clk);
    #1;
    while (stack_wr === 1'b1 && n < 9) begin
      n++;
      @(posedge clk);
      #1;
    end
    chk(n, len);
  endtask
  task automatic dec(input logic [11:0] a, input logic [3:0] s, input logic [7:0] e);
    @(posedge clk) mem_addr <= a;
    #1 chk({sel_ram, sel_prog, sel_boot, sel_vec}, s);
    chk(sel_io, a < `CRS_RAM_LO);
    chk(erased_value, e);
  endtask
  task automatic t_reset;
    rd(`CRS_OFF_ACC, 8'h00);
    rd(`CRS_OFF_FLAGS, 8'h08);
    rd(`CRS_OFF_SPTR, 8'h3f);
    rd(4'h9, 8'h00);
    wr(`CRS_OFF_IDX, 8'h3c);
    wr(`CRS_OFF_FLAGS, 8'h00);
    rd(`CRS_OFF_IDX, 8'h3c);
    chk(flags_out, 5'h00);
    $display("test reset done");
  endtask
  task automatic t_alu;
    alu(`CRS_OP_LDA, 8'h80, 8'h80, 5'h04, 5'h06);
    alu(`CRS_OP_ADD, 8'h80, 8'h00, 5'h03, 5'h17);
    alu(`CRS_OP_LDA, 8'h0f, 8'h0f, 5'h00, 5'h06);
    alu(`CRS_OP_ADD, 8'h01, 8'h10, 5'h10, 5'h17);
    alu(`CRS_OP_SUB, 8'h11, 8'hff, 5'h05, 5'h07);
    alu(`CRS_OP_ADC, 8'h01, 8'h01, 5'h11, 5'h17);
    alu(`CRS_OP_AND, 8'h00, 8'h00, 5'h02, 5'h06);
    alu(`CRS_OP_LDA, 8'hc1, 8'hc1, 5'h04, 5'h06);
    alu(`CRS_OP_ASL, 8'h00, 8'h82, 5'h05, 5'h07);
    alu(`CRS_OP_ROR, 8'h00, 8'hc1, 5'h04, 5'h07);
    alu(`CRS_OP_BTST, 8'h04, 8'hc1, 5'h01, 5'h01);
    alu(`CRS_OP_LDX, 8'h5a, 8'hc1, 5'h00, 5'h00);
    chk(idx_out, 8'h5a);
    wr(`CRS_OFF_OPCMD, 8'h05);
    chk(acc_out, 8'h5a);
    $display("test alu done");
  endtask
  task automatic t_stack;
    op(`CRS_OP_RSP, 8'h00);
    for (int i = 0; i < 65; i++) begin
      op(`CRS_OP_PUSH, 8'h00);
      chk({stack_wr, stack_addr}, {1'b1, 6'h03, 6'h3f - i[5:0]});
    end
    op(`CRS_OP_PULL, 8'h00);
    chk(stack_addr, 12'h0ff);
    op(`CRS_OP_PUSH, 8'h00);
    op(`CRS_OP_RSP, 8'h00);
    op(`CRS_OP_PUSH, 8'h00);
    chk(stack_addr, 12'h0ff);
    $display("test stack done");
  endtask
  task automatic t_irq;
    frame(`CRS_OP_CALL, 2);
    frame(`CRS_OP_INT, 5);
    chk(flags_out[3], 1'b1);
    @(posedge clk) irq_pulse <= 1'b1;
    @(posedge clk) irq_pulse <= 1'b0;
    #1 chk(irq_take, 1'b0);
    wr(`CRS_OFF_FLAGS, 8'h00);
    chk(irq_take, 1'b1);
    $display("test irq done");
  endtask
  task automatic t_decode;
    dec(12'h04f, 4'h0, 8'hff);
    dec(12'h050, 4'h8, 8'hff);
    dec(12'h100, 4'h4, 8'hff);
    dec(12'heff, 4'h4, 8'hff);
    dec(12'hf00, 4'h2, 8'h00);
    dec(12'hfef, 4'h2, 8'hff);
    dec(12'hfff, 4'h1, 8'hff);
    @(posedge clk) mem_erased <= 1'b0;
    dec(12'h100, 4'h4, 8'h00);
    $display("test decode done");
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_alu;
    t_stack;
    t_irq;
    t_decode;
    finish_test;
  end
  // Whole run needs about 215 cycles
  initial begin
    #20000;
    num_errors++;
    finish_test;
  end
endmodule
`default_nettype wire
